// ===== common/line_timer_defines.vh
// Constants for the output line pulse timer block.
// Assumes a 100 MHz system clock and a register port with one-cycle read latency.
`ifndef LINE_TIMER_DEFINES_VH
`define LINE_TIMER_DEFINES_VH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ            100
`define TICK_US            1
`define TICK_CYCLES        (`CLK_MHZ * `TICK_US)
`define TICK_CNT_W         7
// Last count of the tick divider, 100 cycles less one
`define TICK_LAST          7'h63

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_W             4
`define REG_LINE_CTRL      4'h0
`define REG_DELAY_COUNT    4'h1
`define REG_DURATION_COUNT 4'h2
`define REG_DELAY_BASE     4'h3
`define REG_DURATION_BASE  4'h4
`define REG_STATUS         4'h5

// ---------------------------------------------------------------
// Fields and resets
// ---------------------------------------------------------------
`define COUNT_W            12
`define BASE_W             16
`define SEL_W              2
`define BIT_INVERT         0
`define BIT_USER_LEVEL     1
`define SEL_LSB            2
`define SEL_MSB            3
`define SEL_USER           2'h0
`define SEL_TIMER          2'h1
`define BASE_RESET         16'h0001
`define COUNT_RESET        12'h000

`endif

// ===== hdl/output_line_timer_invert.v
// Output line driver with polarity flip and one delay/duration pulse timer.
// Assumes exposure_window_signal_i is synchronous to clk_i.
// Notes on behaviour
// - Without inversion the transistor conducts exactly when the control signal is one.
// - With inversion the transistor conducts exactly when the control signal is zero.
// - Selecting the timer source routes the single timer's output to the line.
// - There is one timer; a trigger starts its delay while its output stays low.
// - After the full delay the output goes high and the duration count starts at once, unless the duration count is zero, when the timer goes back to idle.
// - After the full duration the output goes low and the timer waits for a trigger.
// - The trigger is the rising edge of the exposure window signal.
// - The inverter also acts on the timer output when it drives the line.
// - The user level is applied before the inverter.
// - The delay is a 0 to 4095 count times the delay time base; here it can come out up to 1 us short, as counting waits for the next tick.
// - The duration is a 0 to 4095 count times the duration time base; after a zero delay it can come out up to 1 us short here.
// - Both time bases reset to one microsecond and step in microseconds.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "line_timer_defines.vh"

module output_line_timer_invert
(
  // Clock and reset
  input  wire                clk_i,
  input  wire                reset_n_i,
  // Register port
  input  wire [`ADDR_W-1:0]  addr_i,
  input  wire [31:0]         wdata_i,
  input  wire                wr_i,
  input  wire                rd_i,
  output reg  [31:0]         rdata_o,
  // Camera side
  input  wire                exposure_window_signal_i,
  // Line
  output wire                output_transistor_o,
  output wire                pulse_timer_output_o
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE     = 2'b00;
  localparam [1:0] ST_DELAY    = 2'b01;
  localparam [1:0] ST_DURATION = 2'b10;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg                  polarity_flip_enable_q;
  reg                  user_level_q;
  reg [`SEL_W-1:0]     line_drive_select_q;
  reg [`COUNT_W-1:0]   delay_count_q;
  reg [`COUNT_W-1:0]   duration_count_q;
  reg [`BASE_W-1:0]    delay_tick_base_q;
  reg [`BASE_W-1:0]    duration_tick_base_q;

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      polarity_flip_enable_q <= 1'b0;
      user_level_q           <= 1'b0;
      line_drive_select_q    <= `SEL_USER;
      delay_count_q          <= `COUNT_RESET;
      duration_count_q       <= `COUNT_RESET;
      delay_tick_base_q      <= `BASE_RESET;
      duration_tick_base_q   <= `BASE_RESET;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `REG_LINE_CTRL:
        begin
          polarity_flip_enable_q <= wdata_i[`BIT_INVERT];
          user_level_q           <= wdata_i[`BIT_USER_LEVEL];
          line_drive_select_q    <= wdata_i[`SEL_MSB:`SEL_LSB];
        end
        `REG_DELAY_COUNT:
        begin
          delay_count_q <= wdata_i[`COUNT_W-1:0];
        end
        `REG_DURATION_COUNT:
        begin
          duration_count_q <= wdata_i[`COUNT_W-1:0];
        end
        `REG_DELAY_BASE:
        begin
          // Zero base is meaningless; keep one microsecond as the floor
          if (wdata_i[`BASE_W-1:0] != {`BASE_W{1'b0}})
            delay_tick_base_q <= wdata_i[`BASE_W-1:0];
        end
        `REG_DURATION_BASE:
        begin
          if (wdata_i[`BASE_W-1:0] != {`BASE_W{1'b0}})
            duration_tick_base_q <= wdata_i[`BASE_W-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Microsecond tick
  // ---------------------------------------------------------------
  reg [`TICK_CNT_W-1:0] tick_cnt_q;
  wire                  us_tick;

  assign us_tick = (tick_cnt_q == `TICK_LAST);

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tick_cnt_q <= {`TICK_CNT_W{1'b0}};
    end
    else if (us_tick)
    begin
      tick_cnt_q <= {`TICK_CNT_W{1'b0}};
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Pulse timer
  // ---------------------------------------------------------------
  reg [1:0]          state_q;
  reg                exp_prev_q;
  reg [`BASE_W-1:0]  base_cnt_q;
  reg [`COUNT_W-1:0] unit_cnt_q;
  reg                timer_out_q;
  wire               trig;
  wire [`BASE_W-1:0] cur_base;
  wire               base_done;

  // Edge detect is combinational, so it adds no cycle of latency after the exposure rise
  assign trig      = exposure_window_signal_i & ~exp_prev_q;
  assign cur_base  = (state_q == ST_DURATION) ? duration_tick_base_q : delay_tick_base_q;
  // Counts advance only on tick boundaries, so a delay may come out up to 1 us short
  assign base_done = us_tick && (base_cnt_q == cur_base - 1'b1);

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q     <= ST_IDLE;
      exp_prev_q  <= 1'b0;
      base_cnt_q  <= {`BASE_W{1'b0}};
      unit_cnt_q  <= {`COUNT_W{1'b0}};
      timer_out_q <= 1'b0;
    end
    else
    begin
      exp_prev_q <= exposure_window_signal_i;
      case (state_q)
        ST_IDLE:
        begin
          timer_out_q <= 1'b0;
          base_cnt_q  <= {`BASE_W{1'b0}};
          unit_cnt_q  <= {`COUNT_W{1'b0}};
          if (trig)
          begin
            if (delay_count_q == `COUNT_RESET)
            begin
              timer_out_q <= (duration_count_q != `COUNT_RESET);
              state_q     <= (duration_count_q != `COUNT_RESET) ? ST_DURATION : ST_IDLE;
            end
            else
              state_q <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          // Triggers are not looked at outside idle
          if (us_tick)
          begin
            if (base_done)
            begin
              base_cnt_q <= {`BASE_W{1'b0}};
              if (unit_cnt_q == delay_count_q - 1'b1)
              begin
                unit_cnt_q <= {`COUNT_W{1'b0}};
                if (duration_count_q == `COUNT_RESET)
                  state_q <= ST_IDLE;
                else
                begin
                  timer_out_q <= 1'b1;
                  state_q     <= ST_DURATION;
                end
              end
              else
              begin
                unit_cnt_q <= unit_cnt_q + 1'b1;
              end
            end
            else
            begin
              base_cnt_q <= base_cnt_q + 1'b1;
            end
          end
        end
        ST_DURATION:
        begin
          if (us_tick)
          begin
            if (base_done)
            begin
              base_cnt_q <= {`BASE_W{1'b0}};
              if (unit_cnt_q == duration_count_q - 1'b1)
              begin
                unit_cnt_q  <= {`COUNT_W{1'b0}};
                timer_out_q <= 1'b0;
                state_q     <= ST_IDLE;
              end
              else
              begin
                unit_cnt_q <= unit_cnt_q + 1'b1;
              end
            end
            else
            begin
              base_cnt_q <= base_cnt_q + 1'b1;
            end
          end
        end
        default:
        begin
          state_q     <= ST_IDLE;
          timer_out_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Line source and inverter
  // ---------------------------------------------------------------
  wire line_ctrl;

  assign pulse_timer_output_o = timer_out_q;
  // Source picked ahead of the inverter so both sources see the same polarity
  assign line_ctrl = (line_drive_select_q == `SEL_TIMER) ? timer_out_q
                                                          : user_level_q;
  assign output_transistor_o = line_ctrl ^ polarity_flip_enable_q;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= 32'h00000000;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `REG_LINE_CTRL:
        begin
          rdata_o <= {28'h0000000, line_drive_select_q, user_level_q, polarity_flip_enable_q};
        end
        `REG_DELAY_COUNT:
        begin
          rdata_o <= {20'h00000, delay_count_q};
        end
        `REG_DURATION_COUNT:
        begin
          rdata_o <= {20'h00000, duration_count_q};
        end
        `REG_DELAY_BASE:
        begin
          rdata_o <= {16'h0000, delay_tick_base_q};
        end
        `REG_DURATION_BASE:
        begin
          rdata_o <= {16'h0000, duration_tick_base_q};
        end
        `REG_STATUS:
        begin
          rdata_o <= {28'h0000000, output_transistor_o, timer_out_q, state_q};
        end
        default:
        begin
          rdata_o <= 32'h00000000;
        end
      endcase
    end
    else
    begin
      // Idle read data sits at zero so stale values never look fresh
      rdata_o <= 32'h00000000;
    end
  end

endmodule // output_line_timer_invert

// ===== bench/line_lamp_model.sv
// Lamp on the output line: lit while the output transistor conducts.
// Assumes the line sits dark whenever the transistor is off.
module line_lamp_model
(
  // Clock
  input  wire logic clk_i,
  // Line
  input  wire logic line_i,
  // Observation
  output wire logic lamp_on_o,
  output int        lit_cycles_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int lit_q = 0;
  // ----
  // Lamp
  // ----
  assign lamp_on_o = line_i;
  assign lit_cycles_o = lit_q;
  // Lit cycles let the bench judge pulse widths from the far side
  always @(posedge clk_i)
    if (line_i)
      lit_q <= lit_q + 1;
endmodule // line_lamp_model

// ===== bench/output_line_timer_invert_assertions.sv
// Checker for output_line_timer_invert, bound to its top ports.
// Assumes 100 clock cycles to a microsecond tick.
`include "line_timer_defines.vh"
module output_line_timer_invert_assertions
(
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               reset_n_i,
  // Register port
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [31:0]        wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [31:0]        rdata_o,
  // Camera side and line
  input wire logic               exposure_window_signal_i,
  input wire logic               output_transistor_o,
  input wire logic               pulse_timer_output_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ctrl_q;
  logic       dly0_q;
  int         hi_q;
  wire        st_rd = rd_i && addr_i == `REG_STATUS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Zero delay starts off a tick boundary, so its pulses are exempt
  always @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      ctrl_q <= 4'h0;
      dly0_q <= 1'b1;
      hi_q   <= 0;
    end
    else
    begin
      if (wr_i && addr_i == `REG_LINE_CTRL)
        ctrl_q <= wdata_i[3:0];
      if (wr_i && addr_i == `REG_DELAY_COUNT)
        dly0_q <= wdata_i[11:0] == 12'h000;
      hi_q <= pulse_timer_output_o ? hi_q + 1 : 0;
    end
  // ----
  // Assertions
  // ----
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero");
  a_status_mirror: assert property (st_rd |=> rdata_o[2] == $past(pulse_timer_output_o)
    && rdata_o[3] == $past(output_transistor_o)) else $error("status mismatch");
  a_user_level: assert property (ctrl_q[3:2] != `SEL_TIMER
    |-> output_transistor_o == (ctrl_q[1] ^ ctrl_q[0])) else $error("user level wrong");
  a_timer_route: assert property (ctrl_q[3:2] == `SEL_TIMER
    |-> output_transistor_o == (pulse_timer_output_o ^ ctrl_q[0])) else $error("timer route");
  a_whole_ticks: assert property ($fell(pulse_timer_output_o) && !dly0_q
    |-> hi_q != 0 && hi_q % `TICK_CYCLES == 0) else $error("pulse not whole ticks");
  a_state_out: assert property (st_rd |=> rdata_o[2] == (rdata_o[1:0] == 2'h2))
    else $error("state and output disagree");
  a_count_width: assert property (rd_i && addr_i == `REG_DELAY_COUNT
    |=> rdata_o[31:12] == 20'h0) else $error("delay count too wide");
  a_unmapped_zero: assert property (rd_i && addr_i > `REG_STATUS |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // output_line_timer_invert_assertions

bind output_line_timer_invert output_line_timer_invert_assertions u_chk
  (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .exposure_window_signal_i(exposure_window_signal_i),
   .output_transistor_o(output_transistor_o), .pulse_timer_output_o(pulse_timer_output_o));

// ===== bench/output_line_timer_invert_bench.sv
// Self-checking bench for output_line_timer_invert with a lamp on the line.
// Assumes the checker binds itself to the design.
`include "line_timer_defines.vh"
module output_line_timer_invert_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i = 0;
  logic               reset_n_i = 0;
  logic [`ADDR_W-1:0] addr_i = 4'h0;
  logic [31:0]        wdata_i = 32'h0;
  logic               wr_i = 0;
  logic               rd_i = 0;
  logic               exposure_window_signal_i = 0;
  logic [31:0]        rdata_o;
  logic               output_transistor_o;
  logic               pulse_timer_output_o;
  logic               lamp_on;
  int                 lit, miscompares, checks, d, h;
  output_line_timer_invert u_dut
  (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .exposure_window_signal_i(exposure_window_signal_i),
   .output_transistor_o(output_transistor_o), .pulse_timer_output_o(pulse_timer_output_o));
  line_lamp_model u_lamp
  (.clk_i(clk_i), .line_i(output_transistor_o), .lamp_on_o(lamp_on), .lit_cycles_o(lit));
  initial
    forever #5 clk_i = ~clk_i;
  // ----
  // Tasks
  // ----
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string n);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk(n, e, rdata_o);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wt(logic v);
    for (int n = 0; pulse_timer_output_o !== v; n++)
    begin
      @(posedge clk_i);
      #1;
      if (n > 2000)
      begin
        miscompares++;
        wrap_up;
      end
    end
  endtask
  // Measures delay and high time; rt pokes a trigger mid-pulse
  task automatic trig(bit rt);
    logic q;
    d = 0;
    h = 0;
    q = 0;
    exposure_window_signal_i <= 1;
    while (pulse_timer_output_o !== 1 && d < 2000)
    begin
      @(posedge clk_i);
      #1 d++;
      exposure_window_signal_i <= 0;
    end
    while (pulse_timer_output_o === 1 && h < 2000)
    begin
      @(posedge clk_i);
      #1 h++;
      exposure_window_signal_i <= rt && h == 2;
    end
    repeat (300)
    begin
      @(posedge clk_i);
      #1 q |= pulse_timer_output_o;
      exposure_window_signal_i <= 0;
    end
    chk("retrigger", 0, q);
  endtask
  task automatic t_reset;
    rd(`REG_DELAY_BASE, 1, "delay base");
    rd(`REG_DURATION_BASE, 1, "dur base");
    rd(`REG_STATUS, 0, "status");
    wr(`REG_DURATION_BASE, 0);
    rd(`REG_DURATION_BASE, 1, "zero base");
    wr(`REG_DELAY_COUNT, 32'hFFFF);
    rd(`REG_DELAY_COUNT, 32'hFFF, "max delay");
    wr(`REG_DURATION_COUNT, 32'hFFFF);
    rd(`REG_DURATION_COUNT, 32'hFFF, "max dur");
    wr(4'hF, 32'hFF);
    rd(4'hF, 0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_levels;
    logic e;
    for (int i = 0; i < 16; i++)
    begin
      wr(`REG_LINE_CTRL, i);
      e = (i[3:2] == 1 ? 1'b0 : i[1]) ^ i[0];
      #1 chk("transistor", e, output_transistor_o);
      chk("lamp", e, lamp_on);
    end
    $display("level test done");
  endtask
  task automatic t_pulse;
    int l0;
    wr(`REG_DELAY_COUNT, 2);
    wr(`REG_DELAY_BASE, 1);
    wr(`REG_DURATION_COUNT, 3);
    wr(`REG_DURATION_BASE, 2);
    wr(`REG_LINE_CTRL, 4);
    l0 = lit;
    trig(1);
    chk("delay", 1, d >= 102 && d <= 201);
    chk("high", 600, h);
    chk("lamp", 600, lit - l0);
    $display("pulse test done");
  endtask
  task automatic t_invert;
    wr(`REG_DELAY_COUNT, 1);
    wr(`REG_DELAY_BASE, 3);
    wr(`REG_DURATION_COUNT, 1);
    wr(`REG_DURATION_BASE, 1);
    wr(`REG_LINE_CTRL, 5);
    exposure_window_signal_i <= 1;
    rd(`REG_STATUS, 32'h9, "in delay");
    wt(1);
    rd(`REG_STATUS, 32'h6, "in pulse");
    wt(0);
    exposure_window_signal_i <= 0;
    rd(`REG_STATUS, 32'h8, "idle");
    $display("invert test done");
  endtask
  task automatic t_edges;
    wr(`REG_DELAY_COUNT, 0);
    trig(0);
    chk("zero delay", 1, d);
    chk("short high", 1, h >= 1 && h <= 100);
    wr(`REG_DURATION_COUNT, 0);
    trig(0);
    chk("zero duration", 2000, d);
    $display("edge test done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1;
    t_reset;
    t_levels;
    t_pulse;
    t_invert;
    t_edges;
    wrap_up;
  end
endmodule // output_line_timer_invert_bench
